/* hdl/bridge_global_defs.vh */
// constants for the global enable and bit-timing register bank
`ifndef BRIDGE_GLOBAL_DEFS_VH
`define BRIDGE_GLOBAL_DEFS_VH

// ======================================================
// register addresses
`define ADDR_MASTER_CONTROL 16'h800F
`define ADDR_TIMING_JUMP_PRESCALE 16'h8030
`define ADDR_TIMING_SEGMENTS 16'h8031

// ======================================================
// reset values
`define RESET_BYTE 8'h00
`define READ_UNMAPPED 8'h00

// ======================================================
// master control fields
`define MC_LABEL_RX_BIT 7
`define MC_LABEL_TX_BIT 6
`define MC_FRAME_RX_BIT 5
`define MC_FRAME_TX_BIT 4
`define MC_REVERSE_BIT 3

// ======================================================
// timing fields
`define JUMP_MSB 7
`define JUMP_LSB 6
`define PRESCALE_MSB 5
`define PRESCALE_LSB 0
`define TRIPLE_BIT 7
`define PHASE2_MSB 6
`define PHASE2_LSB 4
`define SEG1_MSB 3
`define SEG1_LSB 0
`define CODE_OFFSET_3 3'h1
`define CODE_OFFSET_4 4'h1
`define CODE_OFFSET_5 5'h01
`define CODE_OFFSET_7 7'h01
`define PHASE2_ZERO 3'h0
`define SEG1_ZERO 4'h0

// ======================================================
// controller clock synthesis
`define SYS_CLK_MHZ 8'd200
`define CTRL_CLK_MHZ 8'd24
`define TOGGLE_STEP (`CTRL_CLK_MHZ * 8'd2)
`define ACC_ZERO 8'h00

// ======================================================
// timing transfer targets
`define SEL_TIMING_LOW 1'b0
`define SEL_TIMING_HIGH 1'b1

`endif

/* hdl/bridge_global_enable_and_can_timing.v */
// global enables, label reversal and bit-timing bank with transfer to the frame controller
// Function
// - with the label receive enable clear, all eight label receive inputs are ignored.
// - with the label transmit enable clear, no label transmit data leaves and all transmit sequencers are held in reset.
// - with the frame receive enable clear, every frame from the controller is disregarded.
// - with the frame transmit enable clear, no frame is sent and the frame transmit sequencer is held in reset.
// - with the reverse bit set, the label byte is bit-reversed on receive and transmit paths.
// - after the run input rises, both timing registers are copied to the controller's two timing registers.
// - a clock output averaging 24 MHz is provided for the controller's oscillator input.
// - timing register one bits 7:6 hold the jump width in quanta as code plus one.
// - timing register one bits 5:0 hold the prescaler divisor as code plus one.
// - timing register two bit 7 selects triple sampling when one, single when zero.
// - the phase segment two field gives its length as code plus one, code zero invalid.
// - the segment one field gives its length as code plus one, code zero invalid.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_global_defs.vh"

module bridge_global_enable_and_can_timing (
   input wire i_clock,
   input wire i_reset_n,
   // register access
   input wire [15:0] i_reg_addr,
   input wire i_reg_write,
   input wire i_reg_read,
   input wire [7:0] i_reg_wdata,
   output reg [7:0] o_reg_rdata,
   output reg o_reg_rvalid,
   // label bus paths
   input wire [7:0] i_label_rx_active,
   output reg [7:0] o_label_rx_active,
   input wire [7:0] i_rx_label,
   output reg [7:0] o_rx_label,
   input wire [3:0] i_label_tx_data,
   output reg [3:0] o_label_tx_data,
   input wire [7:0] i_tx_label,
   output reg [7:0] o_tx_label,
   output reg o_label_tx_seq_hold,
   // frame paths
   input wire i_frame_rx_valid,
   output reg o_frame_rx_valid,
   input wire i_frame_tx_valid,
   output reg o_frame_tx_valid,
   output reg o_frame_tx_seq_hold,
   // run and controller timing transfer
   input wire i_run,
   output reg o_ctrl_wr_valid,
   output reg o_ctrl_wr_sel,
   output reg [7:0] o_ctrl_wr_data,
   input wire i_ctrl_wr_ready,
   output reg o_ctrl_transfer_done,
   // decoded timing
   output reg [2:0] o_jump_width_quanta,
   output reg [6:0] o_prescale_divisor,
   output reg o_triple_sampling_select,
   output reg [3:0] o_phase_two_quanta,
   output reg [4:0] o_segment_one_quanta,
   output reg o_timing_invalid,
   // controller clock
   output reg o_controller_clock_output
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_SEND_LOW = 2'b01;
   localparam [1:0] ST_SEND_HIGH = 2'b10;

   reg [7:0] master_control_q;
   reg [7:0] timing_jump_prescale_q;
   reg [7:0] timing_segments_q;
   reg run_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [7:0] acc_q;
   wire [8:0] acc_sum;
   wire label_rx_en;
   wire label_tx_en;
   wire frame_rx_en;
   wire frame_tx_en;
   wire label_bit_reverse;
   wire run_rise;
   wire [1:0] jump_code;
   wire [2:0] phase2_code;
   wire [3:0] seg1_code;
   wire [2:0] jump_quanta;
   wire [6:0] prescale_divisor;
   wire [3:0] phase_two_quanta;
   wire [4:0] segment_one_quanta;

   assign label_rx_en = master_control_q[`MC_LABEL_RX_BIT];
   assign label_tx_en = master_control_q[`MC_LABEL_TX_BIT];
   assign frame_rx_en = master_control_q[`MC_FRAME_RX_BIT];
   assign frame_tx_en = master_control_q[`MC_FRAME_TX_BIT];
   assign label_bit_reverse = master_control_q[`MC_REVERSE_BIT];
   assign run_rise = i_run & ~run_q;
   assign jump_code = timing_jump_prescale_q[`JUMP_MSB:`JUMP_LSB];
   assign phase2_code = timing_segments_q[`PHASE2_MSB:`PHASE2_LSB];
   assign seg1_code = timing_segments_q[`SEG1_MSB:`SEG1_LSB];
   assign acc_sum = {1'b0, acc_q} + {1'b0, `TOGGLE_STEP};

   function [7:0] reverse_byte;
      input [7:0] value;
      integer k;
      begin
         for (k = 0; k < 8; k = k + 1) begin
            reverse_byte[k] = value[7 - k];
         end
      end
   endfunction

   // ======================================================
   // code to length decoding
   code_plus_one #(
      .WIDTH(2)
   ) jump_len_u (
      .i_code(jump_code),
      .o_length(jump_quanta)
   );

   code_plus_one #(
      .WIDTH(6)
   ) prescale_len_u (
      .i_code(timing_jump_prescale_q[`PRESCALE_MSB:`PRESCALE_LSB]),
      .o_length(prescale_divisor)
   );

   code_plus_one #(
      .WIDTH(3)
   ) phase_two_len_u (
      .i_code(phase2_code),
      .o_length(phase_two_quanta)
   );

   code_plus_one #(
      .WIDTH(4)
   ) segment_one_len_u (
      .i_code(seg1_code),
      .o_length(segment_one_quanta)
   );

   // ======================================================
   // register storage and readback
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         master_control_q <= `RESET_BYTE;
         timing_jump_prescale_q <= `RESET_BYTE;
         timing_segments_q <= `RESET_BYTE;
         o_reg_rdata <= `READ_UNMAPPED;
         o_reg_rvalid <= 1'b0;
      end else begin
         if (i_reg_write) begin
            case (i_reg_addr)
               `ADDR_MASTER_CONTROL: begin
                  master_control_q <= i_reg_wdata;
               end
               `ADDR_TIMING_JUMP_PRESCALE: begin
                  timing_jump_prescale_q <= i_reg_wdata;
               end
               `ADDR_TIMING_SEGMENTS: begin
                  timing_segments_q <= i_reg_wdata;
               end
               default: begin
               end
            endcase
         end
         o_reg_rvalid <= i_reg_read;
         if (i_reg_read) begin
            case (i_reg_addr)
               `ADDR_MASTER_CONTROL: o_reg_rdata <= master_control_q;
               `ADDR_TIMING_JUMP_PRESCALE: o_reg_rdata <= timing_jump_prescale_q;
               `ADDR_TIMING_SEGMENTS: o_reg_rdata <= timing_segments_q;
               default: o_reg_rdata <= `READ_UNMAPPED;
            endcase
         end
      end
   end

   // ======================================================
   // path gating and label reversal
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_label_rx_active <= 8'h00;
         o_rx_label <= 8'h00;
         o_label_tx_data <= 4'h0;
         o_tx_label <= 8'h00;
         o_label_tx_seq_hold <= 1'b1;
         o_frame_rx_valid <= 1'b0;
         o_frame_tx_valid <= 1'b0;
         o_frame_tx_seq_hold <= 1'b1;
      end else begin
         o_label_rx_active <= label_rx_en ? i_label_rx_active : 8'h00;
         o_label_tx_data <= label_tx_en ? i_label_tx_data : 4'h0;
         o_label_tx_seq_hold <= ~label_tx_en;
         o_frame_rx_valid <= frame_rx_en & i_frame_rx_valid;
         o_frame_tx_valid <= frame_tx_en & i_frame_tx_valid;
         o_frame_tx_seq_hold <= ~frame_tx_en;
         o_rx_label <= label_bit_reverse ? reverse_byte(i_rx_label) : i_rx_label;
         o_tx_label <= label_bit_reverse ? reverse_byte(i_tx_label) : i_tx_label;
      end
   end

   // ======================================================
   // decoded bit timing
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_jump_width_quanta <= `CODE_OFFSET_3;
         o_prescale_divisor <= `CODE_OFFSET_7;
         o_triple_sampling_select <= 1'b0;
         o_phase_two_quanta <= `CODE_OFFSET_4;
         o_segment_one_quanta <= `CODE_OFFSET_5;
         o_timing_invalid <= 1'b1;
      end else begin
         o_jump_width_quanta <= jump_quanta;
         o_prescale_divisor <= prescale_divisor;
         o_triple_sampling_select <= timing_segments_q[`TRIPLE_BIT];
         o_phase_two_quanta <= phase_two_quanta;
         o_segment_one_quanta <= segment_one_quanta;
         // zero phase two or segment one codes and a phase two not above the jump width are flagged
         o_timing_invalid <= (phase2_code == `PHASE2_ZERO) | (seg1_code == `SEG1_ZERO)
                             | (phase2_code <= {1'b0, jump_code});
      end
   end

   // ======================================================
   // timing transfer to the controller
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (run_rise) begin
               state_d = ST_SEND_LOW;
            end
         end
         ST_SEND_LOW: begin
            if (i_ctrl_wr_ready) begin
               state_d = ST_SEND_HIGH;
            end
         end
         ST_SEND_HIGH: begin
            if (i_ctrl_wr_ready) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         run_q <= 1'b0;
         state_q <= ST_IDLE;
         o_ctrl_wr_valid <= 1'b0;
         o_ctrl_wr_sel <= `SEL_TIMING_LOW;
         o_ctrl_wr_data <= `RESET_BYTE;
         o_ctrl_transfer_done <= 1'b0;
      end else begin
         run_q <= i_run;
         state_q <= state_d;
         o_ctrl_transfer_done <= (state_q == ST_SEND_HIGH) & i_ctrl_wr_ready;
         case (state_d)
            ST_SEND_LOW: begin
               o_ctrl_wr_valid <= 1'b1;
               o_ctrl_wr_sel <= `SEL_TIMING_LOW;
               o_ctrl_wr_data <= timing_jump_prescale_q;
            end
            ST_SEND_HIGH: begin
               o_ctrl_wr_valid <= 1'b1;
               o_ctrl_wr_sel <= `SEL_TIMING_HIGH;
               o_ctrl_wr_data <= timing_segments_q;
            end
            default: begin
               o_ctrl_wr_valid <= 1'b0;
            end
         endcase
      end
   end

   // ======================================================
   // controller clock, fractional toggle at twice 24 MHz
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         acc_q <= `ACC_ZERO;
         o_controller_clock_output <= 1'b0;
      end else begin
         if (acc_sum >= {1'b0, `SYS_CLK_MHZ}) begin
            acc_q <= acc_sum[7:0] - `SYS_CLK_MHZ;
            o_controller_clock_output <= ~o_controller_clock_output;
         end else begin
            acc_q <= acc_sum[7:0];
         end
      end
   end

endmodule // bridge_global_enable_and_can_timing

// ======================================================
// length from a code stored as length minus one
module code_plus_one #(
   parameter WIDTH = 2
) (
   input wire [WIDTH-1:0] i_code,
   output wire [WIDTH:0] o_length
);

   assign o_length = {1'b0, i_code} + {{WIDTH{1'b0}}, 1'b1};

endmodule // code_plus_one
`default_nettype wire

/* tb/bridge_global_assertions.sv */
// port checker for the global enable and timing bank
`timescale 1ns/1ps
`default_nettype none
`include "bridge_global_defs.vh"
module bridge_global_assertions (
   input wire i_clock,
   input wire i_reset_n,
   input wire [15:0] i_reg_addr,
   input wire i_reg_write,
   input wire [7:0] i_reg_wdata,
   input wire [7:0] i_label_rx_active,
   input wire [7:0] o_label_rx_active,
   input wire [7:0] i_rx_label,
   input wire [7:0] o_rx_label,
   input wire [3:0] o_label_tx_data,
   input wire o_label_tx_seq_hold,
   input wire i_frame_rx_valid,
   input wire o_frame_rx_valid,
   input wire o_frame_tx_valid,
   input wire o_frame_tx_seq_hold,
   input wire i_run,
   input wire o_ctrl_wr_valid,
   input wire o_ctrl_wr_sel,
   input wire i_ctrl_wr_ready,
   input wire o_ctrl_transfer_done,
   input wire [2:0] o_jump_width_quanta,
   input wire [3:0] o_phase_two_quanta,
   input wire [4:0] o_segment_one_quanta,
   input wire o_timing_invalid,
   input wire o_controller_clock_output
);
   // ====
   // shadow of master control
   reg [7:0] mc_q;
   always @(posedge i_clock or negedge i_reset_n)
      if (!i_reset_n) mc_q <= 8'h00;
      else if (i_reg_write && i_reg_addr == `ADDR_MASTER_CONTROL) mc_q <= i_reg_wdata;
   function automatic [7:0] rev(input [7:0] v);
      for (int k = 0; k < 8; k++) rev[k] = v[7-k];
   endfunction
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   sequence low_accept; o_ctrl_wr_valid && !o_ctrl_wr_sel && i_ctrl_wr_ready; endsequence
   sequence high_accept; o_ctrl_wr_valid && o_ctrl_wr_sel && i_ctrl_wr_ready; endsequence
   sequence done_pulse; !o_ctrl_wr_valid && o_ctrl_transfer_done ##1 !o_ctrl_transfer_done; endsequence
   a_rx_gated: assert property (o_label_rx_active == ($past(mc_q[7]) ? $past(i_label_rx_active) : 8'h00))
      else $error("rx gate");
   a_tx_held: assert property (o_label_tx_seq_hold == !$past(mc_q[6]) && (!o_label_tx_seq_hold || !o_label_tx_data))
      else $error("tx hold");
   a_frame_rx_gated: assert property (o_frame_rx_valid == ($past(i_frame_rx_valid) && $past(mc_q[5])))
      else $error("frame rx gate");
   a_frame_tx_held: assert property (o_frame_tx_seq_hold == !$past(mc_q[4]) && !(o_frame_tx_valid && o_frame_tx_seq_hold))
      else $error("frame tx hold");
   a_label_reverse: assert property (o_rx_label == ($past(mc_q[3]) ? rev($past(i_rx_label)) : $past(i_rx_label)))
      else $error("label order");
   a_xfer_start: assert property ($rose(i_run) && !o_ctrl_wr_valid && !o_ctrl_transfer_done |=> o_ctrl_wr_valid && !o_ctrl_wr_sel)
      else $error("transfer start");
   a_xfer_low_high: assert property (low_accept |=> o_ctrl_wr_valid && o_ctrl_wr_sel)
      else $error("transfer order");
   a_xfer_done: assert property (high_accept |=> done_pulse)
      else $error("transfer end");
   a_ctrl_clock: assert property ($changed(o_controller_clock_output) |=>
      (!$changed(o_controller_clock_output))[*3] ##[1:2] $changed(o_controller_clock_output))
      else $error("clock half period");
   a_timing_flag: assert property (o_timing_invalid == (o_phase_two_quanta == 4'h1 || o_segment_one_quanta == 5'h01
      || o_phase_two_quanta <= {1'b0, o_jump_width_quanta}))
      else $error("timing flag");
endmodule // bridge_global_assertions
bind bridge_global_enable_and_can_timing bridge_global_assertions chk_u (.*);
`default_nettype wire

/* tb/ctrl_timing_model.sv */
// frame controller timing register model
`timescale 1ns/1ps
`default_nettype none
module ctrl_timing_model (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_slow,
   input wire logic i_valid,
   input wire logic i_sel,
   input wire logic [7:0] i_data,
   output logic o_ready,
   output logic [7:0] o_timing_low,
   output logic [7:0] o_timing_high
);
   logic [1:0] wait_q;
   assign o_ready = i_valid && (!i_slow || wait_q == 2'h3);
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wait_q <= 2'h0;
         o_timing_low <= 8'h00;
         o_timing_high <= 8'h00;
      end else if (o_ready) begin
         wait_q <= 2'h0;
         if (i_sel) o_timing_high <= i_data;
         else o_timing_low <= i_data;
      end else if (i_valid) wait_q <= wait_q + 2'h1;
   end
endmodule // ctrl_timing_model
`default_nettype wire

/* tb/bridge_global_enable_and_can_timing_tb.sv */
// self-checking bench for the global enable and timing bank
`timescale 1ns/1ps
`default_nettype none
`include "bridge_global_defs.vh"
module bridge_global_enable_and_can_timing_tb;
   logic i_clock, i_reset_n, i_reg_write, i_reg_read, i_frame_rx_valid, i_frame_tx_valid, i_run, slow;
   logic [15:0] i_reg_addr;
   logic [7:0] i_reg_wdata, i_label_rx_active, i_rx_label, i_tx_label, o_reg_rdata, o_label_rx_active;
   logic [7:0] o_rx_label, o_tx_label, o_ctrl_wr_data, ctl_low, ctl_high;
   logic [3:0] i_label_tx_data, o_label_tx_data, o_phase_two_quanta;
   logic [6:0] o_prescale_divisor;
   logic [4:0] o_segment_one_quanta;
   logic [2:0] o_jump_width_quanta;
   logic o_reg_rvalid, o_label_tx_seq_hold, o_frame_rx_valid, o_frame_tx_valid, o_frame_tx_seq_hold;
   logic o_ctrl_wr_valid, o_ctrl_wr_sel, i_ctrl_wr_ready, o_ctrl_transfer_done, o_timing_invalid;
   logic o_controller_clock_output, o_triple_sampling_select, prev;
   logic [15:0] exp_rd[$], exp_xf[$];
   int mismatches = 0, total_checks = 0, tg;
   integer seed = 32'h9943;
   bridge_global_enable_and_can_timing dut_u (.*);
   ctrl_timing_model far_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_slow(slow), .i_valid(o_ctrl_wr_valid),
      .i_sel(o_ctrl_wr_sel), .i_data(o_ctrl_wr_data), .o_ready(i_ctrl_wr_ready), .o_timing_low(ctl_low),
      .o_timing_high(ctl_high));
   // ====
   // helpers
   function automatic logic [7:0] rev(input logic [7:0] v);
      rev = {<<{v}};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clock) #1;
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_write = 1'b1;
      @(posedge i_clock) #1;
      i_reg_write = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_rd.push_back({8'h00, e});
      @(posedge i_clock) #1;
      i_reg_addr = a;
      i_reg_read = 1'b1;
      @(posedge i_clock) #1;
      i_reg_read = 1'b0;
   endtask
   task automatic gate(input logic [7:0] mc);
      wr(`ADDR_MASTER_CONTROL, mc);
      {i_label_rx_active, i_rx_label, i_tx_label} = {$random(seed), $random(seed)};
      {i_label_tx_data, i_frame_rx_valid, i_frame_tx_valid} = $random(seed);
      @(posedge i_clock) #1;
      chk(o_label_rx_active, mc[7] ? i_label_rx_active : 8'h00, "rx active");
      chk({o_label_tx_data, o_label_tx_seq_hold}, {mc[6] ? i_label_tx_data : 4'h0, !mc[6]}, "tx data");
      chk(o_frame_rx_valid, mc[5] & i_frame_rx_valid, "frame rx");
      chk({o_frame_tx_valid, o_frame_tx_seq_hold}, {mc[4] & i_frame_tx_valid, !mc[4]}, "frame tx");
      chk({o_rx_label, o_tx_label}, mc[3] ? {rev(i_rx_label), rev(i_tx_label)} : {i_rx_label, i_tx_label}, "labels");
      rd(`ADDR_MASTER_CONTROL, mc);
   endtask
   task automatic tm(input logic [7:0] b0, input logic [7:0] b1);
      wr(`ADDR_TIMING_JUMP_PRESCALE, b0);
      wr(`ADDR_TIMING_SEGMENTS, b1);
      rd(`ADDR_TIMING_JUMP_PRESCALE, b0);
      rd(`ADDR_TIMING_SEGMENTS, b1);
      chk(o_jump_width_quanta, b0[7:6] + 16'h1, "jump");
      chk(o_prescale_divisor, b0[5:0] + 16'h1, "prescale");
      chk(o_triple_sampling_select, b1[7], "sampling");
      chk(o_phase_two_quanta, b1[6:4] + 16'h1, "phase two");
      chk(o_segment_one_quanta, b1[3:0] + 16'h1, "segment one");
      chk(o_timing_invalid, b1[6:4] == 0 || b1[3:0] == 0 || b1[6:4] <= b0[7:6], "invalid");
   endtask
   task automatic xf(input logic [7:0] b0, input logic [7:0] b1, input logic s);
      slow = s;
      wr(`ADDR_TIMING_JUMP_PRESCALE, b0);
      wr(`ADDR_TIMING_SEGMENTS, b1);
      exp_xf.push_back({b0, b1});
      @(posedge i_clock) #1;
      i_run = 1'b1;
      for (int n = 0; n < 40 && exp_xf.size() != 0; n++) @(posedge i_clock);
      chk(exp_xf.size(), 0, "transfer finished");
      #1 i_run = 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ====
   // monitor of answers
   always @(posedge i_clock) begin
      if (o_reg_rvalid === 1'b1) chk(o_reg_rdata, exp_rd.pop_front(), "read data");
      if (o_ctrl_transfer_done === 1'b1) chk({ctl_low, ctl_high}, exp_xf.pop_front(), "timing copy");
   end
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      mismatches++;
      test_done;
   end
   // ====
   // main sequence
   initial begin
      {i_reg_write, i_reg_read, i_frame_rx_valid, i_frame_tx_valid, i_run, slow, i_reset_n} = '0;
      {i_reg_addr, i_reg_wdata, i_label_rx_active, i_rx_label, i_tx_label, i_label_tx_data} = '0;
      repeat (5) @(posedge i_clock);
      #1 i_reset_n = 1'b1;
      rd(`ADDR_MASTER_CONTROL, 8'h00);
      rd(`ADDR_TIMING_JUMP_PRESCALE, 8'h00);
      rd(`ADDR_TIMING_SEGMENTS, 8'h00);
      wr(16'h800E, 8'hFF);
      rd(16'h800E, 8'h00);
      gate(8'h00);
      gate(8'hFF);
      for (int i = 0; i < 10; i++) gate($random(seed));
      tm(8'h00, 8'h00);
      tm(8'hFF, 8'hFF);
      tm(8'h40, 8'h2F);
      for (int i = 0; i < 6; i++) tm($random(seed), $random(seed));
      // phase two code 4..7 always exceeds any jump code, segment one never zero
      xf($random(seed), {2'b01, 2'($random(seed)), 4'($random(seed)) | 4'h1}, 1'b0);
      xf($random(seed), {2'b01, 2'($random(seed)), 4'($random(seed)) | 4'h1}, 1'b1);
      tg = 0;
      prev = o_controller_clock_output;
      for (int n = 0; n < 250; n++) begin
         @(posedge i_clock);
         tg += (o_controller_clock_output != prev);
         prev = o_controller_clock_output;
      end
      chk(tg >= 59 && tg <= 61, 1, "clock rate");
      test_done;
   end
endmodule // bridge_global_enable_and_can_timing_tb
`default_nettype wire
